// *** hw/msb_io_map.sv ***
// What this block does
// - Ready bit reads 1 when ready for automatic bus control, else 0.
// - Group fault bit reads low while any fault exists, high otherwise.
// - Each external sensor input appears on its own bit, 1 when applied.
// - Output bit 2 drives the auxiliary LED or actuator output, 1 asserts.
// - Sensor supply overload or short raises the group fault.
// - Actuator output overload raises group fault and cuts that output.
// - Off position drops contactors and clears latched motor faults.
//
// The address-and-strobe port and the register addresses were decided locally.
`include "msb_params.svh"

`default_nettype none

module msb_io_map
    import msb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // Field bus data exchange
    input wire logic fb_wr_valid,
    input wire logic [2:0] fb_wr_data,
    output logic [3:0] fb_rd_data,
    // Operator switches
    input wire logic [1:0] mode_sel,
    input wire logic hand_fwd,
    input wire logic hand_rev,
    // Plant inputs
    input wire logic sensor_a_input,
    input wire logic sensor_b_input,
    input wire logic sensor_supply_fault,
    input wire logic actuator_fault,
    input wire logic motor_overload,
    input wire logic motor_overtemp,
    // Plant outputs
    output logic main_contactor,
    output logic reverse_contactor,
    output logic actuator_output
);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////////////
    msb_mode_t mode;
    logic [2:0] cmd_r, cmd_nxt;
    logic fault_lat_r, fault_lat_nxt;
    logic act_trip_r, act_trip_nxt;
    logic ctrl_en_r, ctrl_en_nxt;
    logic [3:0] irq_stat_r, irq_stat_nxt;
    logic [3:0] irq_mask_r, irq_mask_nxt;
    logic [3:0] fb_in_r, fb_in_nxt;
    logic main_r, main_nxt;
    logic rev_r, rev_nxt;
    logic aux_r, aux_nxt;
    logic irq_r, irq_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic reset_req, reset_req_old, any_fault, is_off;
    logic [3:0] events;

    assign mode = msb_mode_t'(mode_sel);

    always_comb begin
        // Unused code 3 counts as off, the safe side
        is_off = (mode != MSB_MODE_AUTO) && (mode != MSB_MODE_HAND);
        cmd_nxt = fb_wr_valid ? fb_wr_data : cmd_r;
        // Both contactor bits together mean reset, never actuation
        reset_req = cmd_nxt[`MSB_OUT_MAIN] & cmd_nxt[`MSB_OUT_REVERSE];
        reset_req_old = cmd_r[`MSB_OUT_MAIN] & cmd_r[`MSB_OUT_REVERSE];

        // A fault still present re-sets its latch, so set wins over clear
        fault_lat_nxt = motor_overload | motor_overtemp
                      | (fault_lat_r & ~(is_off | reset_req));
        act_trip_nxt = actuator_fault | (act_trip_r & ~(is_off | reset_req));
        any_fault = fault_lat_nxt | act_trip_nxt | sensor_supply_fault;

        fb_in_nxt[`MSB_IN_READY] = (mode == MSB_MODE_AUTO) & ~any_fault & ctrl_en_r;
        fb_in_nxt[`MSB_IN_FAULT_N] = ~any_fault;
        fb_in_nxt[`MSB_IN_SENSOR_A] = sensor_a_input;
        fb_in_nxt[`MSB_IN_SENSOR_B] = sensor_b_input;

        main_nxt = 1'b0;
        rev_nxt = 1'b0;
        case (mode)
            MSB_MODE_AUTO: begin
                if (fb_in_nxt[`MSB_IN_READY] && !reset_req) begin
                    main_nxt = cmd_nxt[`MSB_OUT_MAIN];
                    rev_nxt = cmd_nxt[`MSB_OUT_REVERSE];
                end
            end
            MSB_MODE_HAND: begin
                // Interlock: opposite selections cancel
                if (!any_fault && (hand_fwd != hand_rev)) begin
                    main_nxt = hand_fwd;
                    rev_nxt = hand_rev;
                end
            end
            default: begin
                main_nxt = 1'b0;
                rev_nxt = 1'b0;
            end
        endcase
        // Tripped output stays dead until a reset request or the off position clears the trip
        aux_nxt = cmd_nxt[`MSB_OUT_AUX] & ~act_trip_nxt;

        ctrl_en_nxt = ctrl_en_r;
        irq_mask_nxt = irq_mask_r;
        if (reg_wr && reg_hit(reg_addr, `MSB_OFF_CTRL)) begin
            ctrl_en_nxt = reg_wdata[0];
        end
        if (reg_wr && reg_hit(reg_addr, `MSB_OFF_IRQ_MASK)) begin
            irq_mask_nxt = reg_wdata[3:0];
        end

        events[`MSB_IRQ_FAULT] = any_fault & fb_in_r[`MSB_IN_FAULT_N];
        events[`MSB_IRQ_RESET_REQ] = reset_req & ~reset_req_old;
        events[`MSB_IRQ_SENSOR] = (fb_in_nxt[3:2] != fb_in_r[3:2]);
        events[`MSB_IRQ_ACT_TRIP] = act_trip_nxt & ~act_trip_r;
        irq_stat_nxt = irq_stat_r;
        if (reg_wr && reg_hit(reg_addr, `MSB_OFF_IRQ_STAT)) begin
            irq_stat_nxt = irq_stat_r & ~reg_wdata[3:0];
        end
        irq_stat_nxt = irq_stat_nxt | events;
        irq_nxt = |(irq_stat_nxt & irq_mask_nxt);

        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `MSB_OFF_IO_STATE: rdata_nxt = {22'h00_0000, act_trip_r, fault_lat_r,
                                                aux_r, rev_r, main_r, cmd_r[0], fb_in_r};
                `MSB_OFF_CTRL: rdata_nxt = {31'h0000_0000, ctrl_en_r};
                `MSB_OFF_IRQ_STAT: rdata_nxt = {28'h000_0000, irq_stat_r};
                `MSB_OFF_IRQ_MASK: rdata_nxt = {28'h000_0000, irq_mask_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_r <= 3'h0;
            fault_lat_r <= 1'b0;
            act_trip_r <= 1'b0;
            ctrl_en_r <= `MSB_CTRL_RST;
            irq_stat_r <= 4'h0;
            irq_mask_r <= `MSB_MASK_RST;
            fb_in_r <= 4'h2;
            main_r <= 1'b0;
            rev_r <= 1'b0;
            aux_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            cmd_r <= cmd_nxt;
            fault_lat_r <= fault_lat_nxt;
            act_trip_r <= act_trip_nxt;
            ctrl_en_r <= ctrl_en_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            fb_in_r <= fb_in_nxt;
            main_r <= main_nxt;
            rev_r <= rev_nxt;
            aux_r <= aux_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = irq_r;
    assign fb_rd_data = fb_in_r;
    assign main_contactor = main_r;
    assign reverse_contactor = rev_r;
    assign actuator_output = aux_r;

    ////////////////////////////////////////////////////////////////////////////////
    AST_NOT_READY_OUTSIDE_AUTO: assert property (@(posedge clk) disable iff (rst)
        (mode_sel != 2'h1) |=> !fb_rd_data[`MSB_IN_READY])
        else $error("ready reported outside auto mode");

    AST_OVERLOAD_FAULT: assert property (@(posedge clk) disable iff (rst)
        motor_overload |=> !fb_rd_data[`MSB_IN_FAULT_N] && !fb_rd_data[`MSB_IN_READY])
        else $error("overload not shown as group fault");

    AST_SENSOR_FOLLOW: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> fb_rd_data[3:2] == $past({sensor_b_input, sensor_a_input}))
        else $error("sensor bits do not follow inputs");

    AST_NO_BOTH_CONTACTORS: assert property (@(posedge clk) disable iff (rst)
        !(main_contactor && reverse_contactor))
        else $error("both contactors actuated");

    AST_RESET_NOT_ACTUATE: assert property (@(posedge clk) disable iff (rst)
        fb_wr_valid && fb_wr_data[1:0] == 2'h3 |=> !main_contactor && !reverse_contactor)
        else $error("reset request actuated a contactor");

    AST_AUX_CLEARED: assert property (@(posedge clk) disable iff (rst)
        fb_wr_valid && !fb_wr_data[2] |=> !actuator_output)
        else $error("aux output on after zero written");

    AST_SUPPLY_FAULT: assert property (@(posedge clk) disable iff (rst)
        sensor_supply_fault |=> !fb_rd_data[`MSB_IN_FAULT_N])
        else $error("sensor supply fault not reported");

    AST_ACT_TRIP: assert property (@(posedge clk) disable iff (rst)
        actuator_fault |=> !actuator_output && !fb_rd_data[`MSB_IN_FAULT_N])
        else $error("actuator fault did not cut output");

    AST_OFF_DROPS: assert property (@(posedge clk) disable iff (rst)
        (mode_sel == 2'h0) |=> !main_contactor && !reverse_contactor)
        else $error("contactor on in off position");

    AST_OFF_CLEARS: assert property (@(posedge clk) disable iff (rst)
        (mode_sel == 2'h0) && !motor_overload && !motor_overtemp && !actuator_fault
        && !sensor_supply_fault |=> fb_rd_data[`MSB_IN_FAULT_N])
        else $error("off position did not clear latched fault");

endmodule : msb_io_map

`default_nettype wire

// *** hw/msb_params.svh ***
`ifndef MSB_PARAMS_SVH
`define MSB_PARAMS_SVH

// Register byte offsets
`define MSB_OFF_IO_STATE 8'h00
`define MSB_OFF_CTRL 8'h04
`define MSB_OFF_IRQ_STAT 8'h08
`define MSB_OFF_IRQ_MASK 8'h0c

// Slave input bits seen by the bus master
`define MSB_IN_READY 0
`define MSB_IN_FAULT_N 1
`define MSB_IN_SENSOR_A 2
`define MSB_IN_SENSOR_B 3

// Slave output bits written by the bus master
`define MSB_OUT_MAIN 0
`define MSB_OUT_REVERSE 1
`define MSB_OUT_AUX 2

// Interrupt status bits
`define MSB_IRQ_FAULT 0
`define MSB_IRQ_RESET_REQ 1
`define MSB_IRQ_SENSOR 2
`define MSB_IRQ_ACT_TRIP 3

// Reset values
`define MSB_CTRL_RST 1'h1
`define MSB_MASK_RST 4'h0

`endif

// *** hw/msb_pkg.sv ***
`default_nettype none

package msb_pkg;

    // Position of the operating-mode key switch
    typedef enum logic [1:0] {
        MSB_MODE_OFF,
        MSB_MODE_AUTO,
        MSB_MODE_HAND
    } msb_mode_t;

endpackage : msb_pkg

`default_nettype wire

// *** testbench/msb_fb_master.sv ***
`default_nettype none

module msb_fb_master (
    // Clock
    input wire logic clk,
    // Slave data exchange
    output logic fb_wr_valid,
    output logic [2:0] fb_wr_data,
    input wire logic [3:0] fb_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        fb_wr_valid = 1'b0;
        fb_wr_data = 3'h0;
    end

    // Bit 0 main, bit 1 reverse, both together ask for a fault reset
    task automatic send(input logic [2:0] d);
        @(posedge clk);
        fb_wr_valid <= 1'b1;
        fb_wr_data <= d;
        @(posedge clk);
        fb_wr_valid <= 1'b0;
        // Stale data must not leak through once valid drops
        fb_wr_data <= ~d;
    endtask : send
endmodule : msb_fb_master

`default_nettype wire

// *** testbench/msb_io_map_tb.sv ***
`default_nettype none

module msb_io_map_tb import msb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq, fb_wr_valid;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic [2:0] fb_wr_data;
    logic [3:0] fb_rd_data;
    logic [1:0] mode_sel = MSB_MODE_OFF;
    logic sa = 1'b0, sb = 1'b0, sf = 1'b0, af = 1'b0, mo = 1'b0;
    logic mt = 1'b0, hf = 1'b0, hr = 1'b0;
    logic main_c, rev_c, act_o;
    int mismatches = 0, n_compared = 0;
    // Behavioural model state
    int auto_m = 0, sf_m = 0, at_m = 0, mf_m = 0, sa_m = 0, sb_m = 0, en_m = 1;

    always #5 clk = ~clk;

    msb_io_map msb_io_map_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .fb_wr_valid(fb_wr_valid), .fb_wr_data(fb_wr_data), .fb_rd_data(fb_rd_data),
        .mode_sel(mode_sel), .hand_fwd(hf), .hand_rev(hr), .sensor_a_input(sa),
        .sensor_b_input(sb), .sensor_supply_fault(sf), .actuator_fault(af),
        .motor_overload(mo), .motor_overtemp(mt), .main_contactor(main_c),
        .reverse_contactor(rev_c), .actuator_output(act_o));

    msb_fb_master msb_fb_master_i (.clk(clk), .fb_wr_valid(fb_wr_valid),
        .fb_wr_data(fb_wr_data), .fb_rd_data(fb_rd_data));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_in();
        logic f;
        f = (sf_m | at_m | mf_m) != 0;
        chk({28'h0, fb_rd_data}, {28'h0, sb_m[0], sa_m[0], !f, auto_m[0] & en_m[0] & !f},
            "inputs");
    endtask : chk_in

    task automatic chk_out(input logic [2:0] e);
        chk({29'h0, act_o, rev_c, main_c}, {29'h0, e}, "outputs");
    endtask : chk_out

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e, "read");
        // Read data stands for one cycle only
        @(posedge clk);
        #1 chk(reg_rdata, 32'h0, "read idle");
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        v = $urandom(95289);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        step(2);
        chk_in();
        rd(8'h04, 32'h1);
        rd(8'h0c, 32'h0);
        rd(8'h40, 32'h0);
        @(posedge clk) mode_sel <= MSB_MODE_AUTO;
        auto_m = 1;
        step(2);
        chk_in();
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            @(posedge clk);
            {sb, sa} <= v[1:0];
            {sb_m, sa_m} = {31'h0, v[1], 31'h0, v[0]};
            step(2);
            chk_in();
        end
        $display("test inputs done");
        for (int i = 0; i < 3; i++) begin
            msb_fb_master_i.send(3'b001 << i);
            step(1);
            chk_out(3'b001 << i);
        end
        @(posedge clk) sf <= 1'b1;
        sf_m = 1;
        step(2);
        chk_in();
        @(posedge clk) sf <= 1'b0;
        sf_m = 0;
        step(2);
        chk_in();
        @(posedge clk) af <= 1'b1;
        at_m = 1;
        step(2);
        chk_in();
        chk_out(3'b000);
        @(posedge clk) af <= 1'b0;
        step(2);
        chk_in();
        msb_fb_master_i.send(3'b011);
        at_m = 0;
        step(1);
        chk_out(3'b000);
        chk_in();
        msb_fb_master_i.send(3'b101);
        step(1);
        chk_out(3'b101);
        $display("test outputs done");
        @(posedge clk) mo <= 1'b1;
        mf_m = 1;
        step(2);
        @(posedge clk) mo <= 1'b0;
        step(2);
        chk_in();
        @(posedge clk) mode_sel <= MSB_MODE_OFF;
        {auto_m, mf_m} = 0;
        step(2);
        chk_in();
        chk({31'h0, main_c}, 32'h0, "main off");
        @(posedge clk) mode_sel <= MSB_MODE_AUTO;
        auto_m = 1;
        $display("test mode done");
        // Earlier events left status bits set
        wr(8'h08, 32'hf);
        rd(8'h08, 32'h0);
        wr(8'h0c, 32'h4);
        @(posedge clk) sa <= ~sa;
        sa_m = !sa_m;
        step(3);
        chk({31'h0, irq}, 32'h1, "irq set");
        rd(8'h08, 32'h4);
        wr(8'h08, 32'h4);
        @(posedge clk) sf <= 1'b1;
        step(3);
        chk({31'h0, irq}, 32'h0, "irq masked");
        rd(8'h08, 32'h1);
        $display("test irq done");
        @(posedge clk) sf <= 1'b0;
        wr(8'h04, 32'h0);
        en_m = 0;
        step(2);
        chk_in();
        rd(8'h04, 32'h0);
        wr(8'h04, 32'h1);
        en_m = 1;
        @(posedge clk) mt <= 1'b1;
        mf_m = 1;
        step(2);
        chk_in();
        @(posedge clk) mt <= 1'b0;
        step(2);
        chk_in();
        // Unused selector code must behave as off
        @(posedge clk) mode_sel <= 2'h3;
        {auto_m, mf_m} = 0;
        step(2);
        chk_in();
        chk_out(3'b100);
        @(posedge clk) mode_sel <= MSB_MODE_HAND;
        hf <= 1'b1;
        step(2);
        chk_out(3'b101);
        chk_in();
        @(posedge clk) hr <= 1'b1;
        step(2);
        chk_out(3'b100);
        $display("test ctrl and hand done");
        finish_test();
    end
endmodule : msb_io_map_tb

`default_nettype wire
